// *** fplsb_core.sv ***
`timescale 1ns/1ps
`include "fplsb_regs.svh"
// Function
// - Load/store address is base register plus sign-extended 16-bit displacement.
// - Misaligned load or store raises alignment fault, access not completed.
// - Single load widens 8-bit memory exponent to 11-bit register exponent.
// - Single load: sign, mapped exponent, fraction 22:0, zeros in 28:0.
// - Longword integer sits in bits 63:62,58:29; 61:59 ignored; 28:0 zero.
// - Double/quadword load copies all 64 memory bits unchanged.
// - Legacy single store writes 44:29, then 63:62, then 58:45.
// - Single/longword store writes bits 63:62 then 58:29, unchecked.
// - Legacy double store reverses order of the four 16-bit words.
// - Double/quadword store writes all 64 register bits unchanged.
// - Faults: access violation, read/write fault, alignment, translation invalid.
// - Branches never interpret the value and never trap.
// - Branch test uses sign and zero-ness of other 63 bits.
// - Nonzero with sign 0 is positive; sign 1 is negative.
// - Six branch conditions decoded from opcode.
// - Target is displacement shifted two, sign-extended, plus updated PC.
// - Condition true loads target into PC, else next sequential.
// - Branch displacement is 21-bit signed, PC-relative only.
// - Most negative integer pattern counts as zero in branch tests.
module fplsb_core (
  input  wire logic                [0:0]  ref_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       opValid,
  input  wire fplsb_pkg::fplsb_op_t       opCode,
  input  wire logic                [63:0] base_integer_reg,
  input  wire logic                [63:0] float_operand_reg,
  input  wire logic                [15:0] memDisp,
  input  wire logic                [20:0] branchDisp,
  input  wire logic                [63:0] instrPc,
  input  wire logic                       memDone,
  input  wire logic                [63:0] memReadData,
  input  wire logic                       memAccViol,
  input  wire logic                       memFaultRw,
  input  wire logic                       memTransInvalid,
  output logic                            busy,
  output logic                            memReq,
  output logic                            memWrite,
  output logic                     [63:0] memAddr,
  output logic                     [63:0] memWriteData,
  output logic                            memQuad,
  output logic                            regWriteEn,
  output logic                     [63:0] regWriteData,
  output logic                            pcLoad,
  output logic                     [63:0] nextPc,
  output logic                            opDone,
  output logic                            faultAlign,
  output logic                            faultAccViol,
  output logic                            faultOnRead,
  output logic                            faultOnWrite,
  output logic                            faultTransInvalid
);
  import fplsb_pkg::*;

  fplsb_state_t state;
  fplsb_state_t next_state;
  fplsb_op_t    heldOp;
  logic [63:0]  heldFloat;

  function automatic logic isLoadOp(input fplsb_op_t op);
    isLoadOp = (op == FPLSB_OP_LOAD_SINGLE) || (op == FPLSB_OP_LOAD_DOUBLE);
  endfunction

  function automatic logic isQuadOp(input fplsb_op_t op);
    isQuadOp = (op == FPLSB_OP_LOAD_DOUBLE) || (op == FPLSB_OP_STORE_LDOUBLE) ||
               (op == FPLSB_OP_STORE_DOUBLE);
  endfunction

  function automatic logic isMemOp(input fplsb_op_t op);
    isMemOp = isLoadOp(op) || (op == FPLSB_OP_STORE_LSINGLE) ||
              (op == FPLSB_OP_STORE_LDOUBLE) || (op == FPLSB_OP_STORE_SINGLE) ||
              (op == FPLSB_OP_STORE_DOUBLE);
  endfunction

  // Effective address
  wire [63:0] dispExt = {{(64-`FPLSB_DISP_MEM_W){memDisp[15]}}, memDisp};
  wire [63:0] effAddr = base_integer_reg + dispExt;
  wire [63:0] alignMask = isQuadOp(opCode) ? `FPLSB_ALIGN8_MASK : `FPLSB_ALIGN4_MASK;
  wire        misaligned = ((effAddr & alignMask) != `FPLSB_ZERO64);

  // Store data reordering
  wire [31:0] legacySingle = {heldFloat[44:29], heldFloat[63:62], heldFloat[58:45]};
  wire [31:0] ieeeSingle = {heldFloat[63:62], heldFloat[58:29]};
  // Legacy double leaves with its four words in reverse order
  wire [63:0] legacyDouble;
  genvar w;
  generate
    for (w = 0; w < `FPLSB_WORDS64; w = w + 1) begin : gWordSwap
      assign legacyDouble[`FPLSB_WORD_W*w +: `FPLSB_WORD_W] =
        heldFloat[`FPLSB_WORD_W*(`FPLSB_WORDS64-1-w) +: `FPLSB_WORD_W];
    end
  endgenerate
  wire [63:0] storeData =
    (heldOp == FPLSB_OP_STORE_LSINGLE) ? {`FPLSB_ZERO32, legacySingle} :
    (heldOp == FPLSB_OP_STORE_SINGLE)  ? {`FPLSB_ZERO32, ieeeSingle} :
    (heldOp == FPLSB_OP_STORE_LDOUBLE) ? legacyDouble :
    heldFloat;

  // Load data reordering
  wire [10:0] mappedExp;
  fplsb_exp_map uExpMap (
    .memExp (memReadData[30:23]),
    .regExp (mappedExp)
  );
  // Integer longwords land in 63:62,58:29 by the same placement
  wire [63:0] singleLoad = {memReadData[31], mappedExp, memReadData[22:0],
                            `FPLSB_ZERO29};
  wire [63:0] loadData = (heldOp == FPLSB_OP_LOAD_SINGLE) ? singleLoad
                                                         : memReadData;
  wire anyMemFault = memAccViol | memFaultRw | memTransInvalid;

  // Branch test: pure bit inspection, no trap path exists
  wire signBit = float_operand_reg[63];
  wire restZero = (float_operand_reg[62:0] == `FPLSB_ZERO63);
  wire isZeroV = restZero;
  wire isPosV = ~restZero & ~signBit;
  wire isNegV = ~restZero & signBit;
  logic brTaken;
  always_comb begin
    case (opCode)
      FPLSB_OP_BR_ZERO: begin
        brTaken = isZeroV;
      end
      FPLSB_OP_BR_NONNEG: begin
        brTaken = isZeroV | isPosV;
      end
      FPLSB_OP_BR_POS: begin
        brTaken = isPosV;
      end
      FPLSB_OP_BR_NONPOS: begin
        brTaken = isZeroV | isNegV;
      end
      FPLSB_OP_BR_NEG: begin
        brTaken = isNegV;
      end
      FPLSB_OP_BR_NONZERO: begin
        brTaken = ~isZeroV;
      end
      default: begin
        brTaken = 1'h0;
      end
    endcase
  end
  wire isBranch = opCode[3];
  wire [63:0] updatedPc = instrPc + `FPLSB_PC_STEP;
  wire [63:0] brOffset = {{(64-`FPLSB_DISP_BR_W-2){branchDisp[20]}},
                          branchDisp, `FPLSB_ZERO2};
  wire [63:0] brTarget = updatedPc + brOffset;
  wire [63:0] brNextPc = brTaken ? brTarget : updatedPc;

  wire startMem = opValid && (state == FPLSB_ST_IDLE) && isMemOp(opCode);
  wire startBr = opValid && (state == FPLSB_ST_IDLE) && isBranch;

  always_comb begin
    case (state)
      FPLSB_ST_IDLE: begin
        next_state = (startMem && !misaligned) ? FPLSB_ST_MEM : FPLSB_ST_IDLE;
      end
      FPLSB_ST_MEM: begin
        next_state = memDone ? FPLSB_ST_DONE : FPLSB_ST_MEM;
      end
      FPLSB_ST_DONE: begin
        next_state = FPLSB_ST_IDLE;
      end
      default: begin
        next_state = FPLSB_ST_IDLE;
      end
    endcase
  end

  // Completion decode shared by the result registers
  wire memAccept              = startMem && !misaligned;
  wire alignReject            = startMem && misaligned;
  wire memFinish              = (state == FPLSB_ST_MEM) && memDone;
  wire heldIsLoad             = isLoadOp(heldOp);
  wire loadFinish             = memFinish && heldIsLoad;

  // Next values of the registered outputs
  wire next_busy              = (next_state != FPLSB_ST_IDLE);
  wire next_regWriteEn        = loadFinish && !anyMemFault;
  wire next_pcLoad            = startBr && brTaken;
  wire next_opDone            = startBr || alignReject || memFinish;
  wire next_faultAccViol      = memFinish && memAccViol;
  wire next_faultOnRead       = loadFinish && memFaultRw;
  wire next_faultOnWrite      = memFinish && memFaultRw && !heldIsLoad;
  wire next_faultTransInvalid = memFinish && memTransInvalid;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= FPLSB_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Operand held through the access so store data cannot shift under it
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      heldOp    <= FPLSB_OP_NONE;
      heldFloat <= `FPLSB_ZERO64;
    end else if (startMem) begin
      heldOp    <= opCode;
      heldFloat <= float_operand_reg;
    end
  end

  // Request stands until the far side answers
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memReq <= 1'h0;
    end else if (memAccept) begin
      memReq <= 1'h1;
    end else if (memDone) begin
      memReq <= 1'h0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memWrite <= 1'h0;
    end else if (memAccept) begin
      memWrite <= !isLoadOp(opCode);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memAddr <= `FPLSB_ZERO64;
    end else if (memAccept) begin
      memAddr <= effAddr;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memQuad <= 1'h0;
    end else if (memAccept) begin
      memQuad <= isQuadOp(opCode);
    end
  end

  // Busy spans the done cycle, so a new op waits one edge
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'h0;
    end else begin
      busy <= next_busy;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      memWriteData <= `FPLSB_ZERO64;
    end else begin
      memWriteData <= storeData;
    end
  end

  // Results and faults are one-cycle pulses; branches have no trap path
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regWriteEn <= 1'h0;
    end else begin
      regWriteEn <= next_regWriteEn;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      regWriteData <= `FPLSB_ZERO64;
    end else if (loadFinish) begin
      regWriteData <= loadData;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pcLoad <= 1'h0;
    end else begin
      pcLoad <= next_pcLoad;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      nextPc <= `FPLSB_ZERO64;
    end else if (startBr) begin
      nextPc <= brNextPc;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      opDone <= 1'h0;
    end else begin
      opDone <= next_opDone;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultAlign <= 1'h0;
    end else begin
      faultAlign <= alignReject;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultAccViol <= 1'h0;
    end else begin
      faultAccViol <= next_faultAccViol;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultOnRead <= 1'h0;
    end else begin
      faultOnRead <= next_faultOnRead;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultOnWrite <= 1'h0;
    end else begin
      faultOnWrite <= next_faultOnWrite;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      faultTransInvalid <= 1'h0;
    end else begin
      faultTransInvalid <= next_faultTransInvalid;
    end
  end
endmodule

// *** fplsb_core_sva.sv ***
`timescale 1ns/1ps
module fplsb_core_sva (
  input wire logic                 [0:0]  ref_clk,
  input wire logic                        sys_rst,
  input wire logic                        opValid,
  input wire fplsb_pkg::fplsb_op_t        opCode,
  input wire logic                 [63:0] base_integer_reg,
  input wire logic                 [63:0] float_operand_reg,
  input wire logic                 [15:0] memDisp,
  input wire logic                 [20:0] branchDisp,
  input wire logic                 [63:0] instrPc,
  input wire logic                        memDone,
  input wire logic                 [63:0] memReadData,
  input wire logic                        memFaultRw,
  input wire logic                        busy,
  input wire logic                        memReq,
  input wire logic                        memWrite,
  input wire logic                 [63:0] memAddr,
  input wire logic                        memQuad,
  input wire logic                        regWriteEn,
  input wire logic                 [63:0] regWriteData,
  input wire logic                        pcLoad,
  input wire logic                 [63:0] nextPc,
  input wire logic                        opDone,
  input wire logic                        faultAlign,
  input wire logic                        faultOnRead
);
  import fplsb_pkg::*;
  wire        take  = opValid && !busy;
  wire        isBr  = opCode >= FPLSB_OP_BR_ZERO;
  wire        memOp = opCode != FPLSB_OP_NONE && !isBr;
  wire [63:0] ea    = base_integer_reg + {{48{memDisp[15]}}, memDisp};
  // Odd opcodes are the 32-bit formats
  wire        mis   = |(ea[2:0] & (opCode[0] ? 3'h3 : 3'h7));
  wire [63:0] tgt   = instrPc + 64'h4 + {{41{branchDisp[20]}}, branchDisp, 2'h0};
  wire        fz    = float_operand_reg[62:0] == 63'h0;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_addr_form: assert property (take && memOp && !mis |=> memReq && memAddr == $past(ea))
    else $error("bad access address");
  a_align_fault: assert property (take && memOp && mis |=> faultAlign && opDone && !memReq)
    else $error("misalignment not faulted");
  a_fault_read: assert property (memReq && memDone && memFaultRw && !memWrite
    |=> opDone && faultOnRead && !regWriteEn) else $error("read fault lost");
  a_single_fill: assert property (regWriteEn && !$past(memQuad)
    |-> regWriteData[28:0] == 29'h0) else $error("single load low bits set");
  a_load_copy: assert property (regWriteEn && $past(memQuad)
    |-> regWriteData == $past(memReadData)) else $error("double load altered");
  a_branch_clean: assert property (take && isBr |=> opDone && !faultAlign && !memReq)
    else $error("branch misbehaved");
  a_next_pc: assert property (take && isBr
    |=> nextPc == (pcLoad ? $past(tgt) : $past(instrPc) + 64'h4)) else $error("bad next pc");
  a_zero_test: assert property (take && opCode == FPLSB_OP_BR_ZERO
    |=> pcLoad == $past(fz)) else $error("zero test wrong");
endmodule
bind fplsb_core fplsb_core_sva chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .opValid(opValid), .opCode(opCode),
  .base_integer_reg(base_integer_reg), .float_operand_reg(float_operand_reg),
  .memDisp(memDisp), .branchDisp(branchDisp), .instrPc(instrPc), .memDone(memDone),
  .memReadData(memReadData), .memFaultRw(memFaultRw), .busy(busy), .memReq(memReq),
  .memWrite(memWrite), .memAddr(memAddr), .memQuad(memQuad), .regWriteEn(regWriteEn),
  .regWriteData(regWriteData), .pcLoad(pcLoad), .nextPc(nextPc), .opDone(opDone),
  .faultAlign(faultAlign), .faultOnRead(faultOnRead)
);

// *** fplsb_core_test.sv ***
`timescale 1ns/1ps
module fplsb_core_test;
  import fplsb_pkg::*;
  logic [0:0]  ref_clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        opValid = 1'h0;
  fplsb_op_t   opCode = FPLSB_OP_NONE;
  logic [63:0] base_integer_reg = 64'h0, float_operand_reg = 64'h0, instrPc = 64'h0;
  logic [15:0] memDisp = 16'h0;
  logic [20:0] branchDisp = 21'h0;
  logic [3:0]  lat = 4'h0;
  logic [2:0]  fltSel = 3'h0;
  logic [1:0]  wk;
  logic [63:0] rdVal = 64'h0, wd, wa, memReadData, memAddr, memWriteData, regWriteData, nextPc;
  logic        memDone, memAccViol, memFaultRw, memTransInvalid, busy, memReq, memWrite;
  logic        memQuad, regWriteEn, pcLoad, opDone, faultAlign, faultAccViol, faultOnRead;
  logic        faultOnWrite, faultTransInvalid;
  int          n_mismatch = 0, checked = 0;
  fplsb_core uut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .opValid(opValid), .opCode(opCode),
    .base_integer_reg(base_integer_reg), .float_operand_reg(float_operand_reg),
    .memDisp(memDisp), .branchDisp(branchDisp), .instrPc(instrPc), .memDone(memDone),
    .memReadData(memReadData), .memAccViol(memAccViol), .memFaultRw(memFaultRw),
    .memTransInvalid(memTransInvalid), .busy(busy), .memReq(memReq), .memWrite(memWrite),
    .memAddr(memAddr), .memWriteData(memWriteData), .memQuad(memQuad),
    .regWriteEn(regWriteEn), .regWriteData(regWriteData), .pcLoad(pcLoad), .nextPc(nextPc),
    .opDone(opDone), .faultAlign(faultAlign), .faultAccViol(faultAccViol),
    .faultOnRead(faultOnRead), .faultOnWrite(faultOnWrite),
    .faultTransInvalid(faultTransInvalid)
  );
  fplsb_mem_model mem (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .memReq(memReq), .lat(lat), .rdVal(rdVal),
    .fltSel(fltSel), .memDone(memDone), .memReadData(memReadData), .memAccViol(memAccViol),
    .memFaultRw(memFaultRw), .memTransInvalid(memTransInvalid)
  );
  initial forever #20 ref_clk = ~ref_clk;
  task automatic chk(input logic [63:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic run(input fplsb_op_t c, input logic [63:0] b, f, input logic [15:0] d,
                     input logic [20:0] bd);
    @(posedge ref_clk);
    opValid <= 1'h1;
    opCode <= c;
    base_integer_reg <= b;
    instrPc <= b;
    float_operand_reg <= f;
    memDisp <= d;
    branchDisp <= bd;
    @(posedge ref_clk);
    opValid <= 1'h0;
    for (int i = 0; i < 40 && opDone !== 1'h1; i++) begin
      @(negedge ref_clk);
      if (memDone === 1'h1) begin
        wd = memWriteData;
        wa = memAddr;
        wk = {memWrite, memQuad};
      end
    end
    if (opDone !== 1'h1) begin
      n_mismatch++;
      $display("FAIL %0t operation never finished", $time);
    end
  endtask
  task automatic t_load_single;
    logic [31:0] m [4] = '{32'hC0A8_1234, 32'h3F80_0000, 32'h7F80_0001, 32'h0000_0005};
    logic [7:0]  e;
    logic [10:0] x;
    lat <= 4'h2;
    foreach (m[i]) begin
      e = m[i][30:23];
      x = e == 8'hFF ? 11'h7FF : e == 8'h00 ? 11'h000 : {e[7], {3{~e[7]}}, e[6:0]};
      rdVal <= {32'h5A5A_5A5A, m[i]};
      run(FPLSB_OP_LOAD_SINGLE, 64'h1000, 64'h0, 16'hFFFC, 21'h0);
      chk(regWriteData, {m[i][31], x, m[i][22:0], 29'h0});
      chk(wa, 64'h0FFC);
      chk(64'(wk), 64'h0);
    end
  endtask
  task automatic t_load_double;
    rdVal <= 64'h8123_4567_89AB_CDEF;
    lat <= 4'h0;
    run(FPLSB_OP_LOAD_DOUBLE, 64'h2000, 64'h0, 16'h0008, 21'h0);
    chk(regWriteData, 64'h8123_4567_89AB_CDEF);
    chk(64'({regWriteEn, busy}), 64'h3);
    fltSel <= 3'h2;
    run(FPLSB_OP_LOAD_DOUBLE, 64'h2000, 64'h0, 16'h0008, 21'h0);
    chk(64'({faultOnRead, faultOnWrite, regWriteEn, busy}), 64'h9);
    fltSel <= 3'h0;
  endtask
  task automatic t_stores;
    logic [63:0] f = 64'h0123_4567_89AB_CDEF;
    fplsb_op_t   c [4] = '{FPLSB_OP_STORE_LSINGLE, FPLSB_OP_STORE_LDOUBLE,
                           FPLSB_OP_STORE_SINGLE, FPLSB_OP_STORE_DOUBLE};
    logic [63:0] x [4];
    x = '{{32'h0, f[44:29], f[63:62], f[58:45]}, {f[15:0], f[31:16], f[47:32], f[63:48]},
          {32'h0, f[63:62], f[58:29]}, f};
    lat <= 4'h5;
    foreach (c[i]) begin
      run(c[i], 64'h3000, f, 16'h0010, 21'h0);
      chk(wd, x[i]);
      chk(64'(wk), i[0] ? 64'h3 : 64'h2);
    end
    fltSel <= 3'h7;
    run(FPLSB_OP_STORE_DOUBLE, 64'h3000, f, 16'h0010, 21'h0);
    chk(64'({faultAccViol, faultOnRead, faultOnWrite, faultTransInvalid}), 64'hB);
    fltSel <= 3'h0;
  endtask
  task automatic t_misalign;
    run(FPLSB_OP_LOAD_DOUBLE, 64'h1004, 64'h0, 16'h0000, 21'h0);
    chk(64'({faultAlign, regWriteEn, busy}), 64'h4);
    run(FPLSB_OP_STORE_SINGLE, 64'h1001, 64'h0, 16'h0001, 21'h0);
    chk(64'({faultAlign, regWriteEn, busy}), 64'h4);
  endtask
  task automatic t_branches;
    logic [63:0] v [4] = '{64'h0, 64'h8000_0000_0000_0000, 64'h7FF0_0000_0000_0001,
                           64'hFFF8_0000_0000_0000};
    logic [20:0] d;
    logic        z;
    logic        s;
    logic        t;
    for (int k = 8; k < 14; k++)
      foreach (v[i]) begin
        z = v[i][62:0] == 63'h0;
        s = v[i][63];
        t = k == 8 ? z : k == 9 ? !s || z : k == 10 ? !s && !z : k == 11 ? s || z :
            k == 12 ? s && !z : !z;
        // Most negative reach alternates with a short forward hop
        d = i[0] ? 21'h10_0000 : 21'h00_0005;
        run(fplsb_op_t'(k), 64'h0040_0000, v[i], 16'h0, d);
        chk(64'(pcLoad), 64'(t));
        chk(nextPc, t ? 64'h0040_0004 + {{41{d[20]}}, d, 2'h0} : 64'h0040_0004);
      end
  endtask
  initial begin
    // Whole run is a few hundred cycles, far below this 5000-cycle limit, so this only trips on a hang
    #200000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'h0;
    t_load_single;
    t_load_double;
    t_stores;
    t_misalign;
    t_branches;
    print_verdict;
  end
endmodule

// *** fplsb_exp_map.sv ***
`timescale 1ns/1ps
`include "fplsb_regs.svh"
module fplsb_exp_map (
  input  wire logic [7:0]  memExp,
  output logic      [10:0] regExp
);
  wire isOnes = (memExp == `FPLSB_EXP_ONES);
  wire isZero = (memExp == `FPLSB_EXP_ZERO);
  wire [10:0] midExp = {memExp[7], {3{~memExp[7]}}, memExp[6:0]};
  assign regExp = isOnes ? `FPLSB_EXP11_ONES :
                  isZero ? `FPLSB_EXP11_ZERO : midExp;
endmodule

// *** fplsb_mem_model.sv ***
`timescale 1ns/1ps
module fplsb_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        memReq,
  input  wire logic [3:0]  lat,
  input  wire logic [63:0] rdVal,
  input  wire logic [2:0]  fltSel,
  output logic             memDone,
  output logic      [63:0] memReadData,
  output logic             memAccViol,
  output logic             memFaultRw,
  output logic             memTransInvalid
);
  logic [3:0] waitCnt;
  wire        pend = memReq && !memDone;
  // Junk on the data bus outside the done cycle
  assign memReadData     = memDone ? rdVal : ~rdVal;
  assign memAccViol      = memDone && fltSel[0];
  assign memFaultRw      = memDone && fltSel[1];
  assign memTransInvalid = memDone && fltSel[2];
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitCnt <= 4'h0;
      memDone <= 1'h0;
    end else begin
      waitCnt <= pend ? waitCnt + 4'h1 : 4'h0;
      memDone <= pend && waitCnt == lat;
    end
  end
endmodule

// *** fplsb_pkg.sv ***
package fplsb_pkg;
  typedef enum logic [3:0] {
    FPLSB_OP_NONE          = 4'b0000,
    FPLSB_OP_LOAD_SINGLE   = 4'b0001,
    FPLSB_OP_LOAD_DOUBLE   = 4'b0010,
    FPLSB_OP_STORE_LSINGLE = 4'b0011,
    FPLSB_OP_STORE_LDOUBLE = 4'b0100,
    FPLSB_OP_STORE_SINGLE  = 4'b0101,
    FPLSB_OP_STORE_DOUBLE  = 4'b0110,
    FPLSB_OP_BR_ZERO       = 4'b1000,
    FPLSB_OP_BR_NONNEG     = 4'b1001,
    FPLSB_OP_BR_POS        = 4'b1010,
    FPLSB_OP_BR_NONPOS     = 4'b1011,
    FPLSB_OP_BR_NEG        = 4'b1100,
    FPLSB_OP_BR_NONZERO    = 4'b1101
  } fplsb_op_t;
  typedef enum logic [1:0] {
    FPLSB_ST_IDLE = 2'b00,
    FPLSB_ST_MEM  = 2'b01,
    FPLSB_ST_DONE = 2'b10
  } fplsb_state_t;
endpackage

// *** fplsb_regs.svh ***
`ifndef FPLSB_REGS_SVH
`define FPLSB_REGS_SVH
`define FPLSB_DISP_MEM_W  16
`define FPLSB_DISP_BR_W   21
`define FPLSB_PC_STEP     64'h0000_0000_0000_0004
`define FPLSB_ALIGN4_MASK 64'h0000_0000_0000_0003
`define FPLSB_ALIGN8_MASK 64'h0000_0000_0000_0007
`define FPLSB_ZERO64      64'h0000_0000_0000_0000
`define FPLSB_ZERO29      29'h0000_0000
`define FPLSB_ZERO32      32'h0000_0000
`define FPLSB_EXP_ONES    8'hFF
`define FPLSB_EXP_ZERO    8'h00
`define FPLSB_EXP11_ONES  11'h7FF
`define FPLSB_EXP11_ZERO  11'h000
`define FPLSB_ZERO63      63'h0000_0000_0000_0000
`define FPLSB_ZERO2       2'h0
`define FPLSB_WORD_W      16
`define FPLSB_WORDS64     4
`endif
